//--- hdl/flash_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.svh"

module flash_bus_cycle #(
   parameter int ACC_CYC = `ACC_CYC,
   parameter int WP_CYC = `WP_CYC,
   parameter int GAP_CYC = `GAP_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Cycle request
   input wire logic start,
   input wire logic wr,
   input wire logic byte_mode,
   input wire logic [19:0] a_in,
   input wire logic am1_in,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata,
   output logic done,
   // Flash pins
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic [19:0] a,
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe,
   input wire logic [15:0] dq_i
);
   import flash_host_pkg::*;

   bus_ph_t ph_ff;
   logic wr_ff;
   logic [7:0] cnt_ff;
   logic [15:0] dq_meta_ff;
   logic [15:0] dq_sync_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Data pins come from the flash's domain
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dq_meta_ff <= 16'h0000;
         dq_sync_ff <= 16'h0000;
      end else begin
         dq_meta_ff <= dq_i;
         dq_sync_ff <= dq_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Strobes kept separate so the bus never has two drivers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_ff <= PH_IDLE;
         wr_ff <= 1'b0;
         cnt_ff <= 8'h00;
         ce_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         a <= 20'h00000;
         dq_o <= 16'h0000;
         dq_oe <= 16'h0000;
         rdata <= 16'h0000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (ph_ff)
            PH_IDLE: begin
               if (start) begin
                  ph_ff <= PH_SETUP;
                  wr_ff <= wr;
                  ce_n <= 1'b0; // RQ3
                  a <= a_in;
                  if (byte_mode) begin
                     // Byte mode: DQ15 carries the lowest address bit
                     dq_o <= {am1_in, 7'h00, wdata[7:0]}; // RQ1
                     dq_oe <= {1'b1, 7'h00, {8{wr}}}; // RQ1
                  end else begin
                     dq_o <= wdata;
                     dq_oe <= {16{wr}};
                  end
               end
            end
            PH_SETUP: begin
               ph_ff <= PH_STROBE;
               cnt_ff <= 8'h00;
               we_n <= ~wr_ff; // RQ4
               oe_n <= wr_ff; // RQ3
            end
            PH_STROBE: begin
               cnt_ff <= cnt_ff + 8'h01;
               // Reads wait two extra cycles for the data synchroniser
               if (wr_ff ? (cnt_ff == 8'(WP_CYC - 1)) : (cnt_ff == 8'(ACC_CYC + 1))) begin
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  rdata <= byte_mode ? {8'h00, dq_sync_ff[7:0]} : dq_sync_ff; // RQ1
                  ph_ff <= PH_GAP;
                  cnt_ff <= 8'h00;
               end
            end
            PH_GAP: begin
               ce_n <= 1'b1;
               cnt_ff <= cnt_ff + 8'h01;
               if (cnt_ff == 8'(GAP_CYC - 1)) begin
                  dq_oe <= 16'h0000;
                  ph_ff <= PH_IDLE;
                  done <= 1'b1;
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

//--- hdl/flash_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.svh"

// How it works
// RQ1 - Word mode uses all sixteen data lines, byte mode only the low eight.
// RQ2 - Address covers 2M bytes or 1M words depending on width.
// RQ3 - Chip select, write and output strobes are separate active-low pins.
// RQ4 - Commands are plain write cycles into the flash command register.
// RQ5 - Flash latches address and data on each command write.
// RQ6 - Program sequence starts a self-timed program; host only waits.
// RQ7 - In bypass mode a program takes two writes instead of four.
// RQ8 - Erase sequence starts a self-timed erase; host only waits.
// RQ9 - Completion is seen on the ready/busy pin or the toggle bit.
// RQ10 - After completion the flash reads array data and takes new commands.
// RQ11 - Sector erase touches only the addressed sector.
// RQ12 - Flash ignores writes while its supply is too low.
// RQ13 - Protected sectors refuse program and erase.
// RQ14 - Erase can be held, other sectors used, then resumed.
// RQ15 - Reset pin aborts any operation and returns the flash to array read.
// RQ16 - Flash sleeps itself when addresses stay unchanged.
// RQ17 - Host puts the flash in standby by holding chip select high.
// RQ18 - Invalid sequences leave the flash reading array data unchanged.
module flash_host_ctrl #(
   parameter int RST_CYC = `RST_CYC,
   parameter int REC_CYC = `REC_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // User command
   input wire logic cmd_valid,
   input wire flash_host_pkg::op_t cmd_op,
   input wire logic [20:0] cmd_addr,
   input wire logic [15:0] cmd_data,
   output logic cmd_ready,
   // User answer
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic rsp_err,
   // Status
   output logic flash_busy,
   output logic bypass_active,
   output logic byte_mode,
   // Flash pins
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic [19:0] addr,
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe,
   input wire logic [15:0] dq_i,
   output logic byte_n,
   output logic reset_n,
   input wire logic ready_busy_output
);
   import flash_host_pkg::*;

   st_t st_ff;
   op_t op_ff;
   logic [20:0] uaddr_ff;
   logic [15:0] udata_ff;
   logic [2:0] step_ff;
   logic [15:0] cnt_ff;
   logic poll_first_ff;
   logic [15:0] prev_ff;
   logic rdy_meta_ff;
   logic rdy_sync_ff;
   logic start_ff;
   logic wr_ff;
   logic [19:0] a_ff;
   logic am1_ff;
   logic [15:0] wd_ff;
   logic [15:0] bus_rdata;
   logic bus_done;
   logic [37:0] seq;

   ////////////////////////////////////////////////////////////////////////////////
   // Command cycle table: {last, user address, word address, data}
   function automatic logic [37:0] seq_step(input op_t op, input logic [2:0] step,
                                             input logic byp, input logic [15:0] d);
      logic [37:0] r;
      r = {1'b1, 1'b0, 20'h00000, `CMD_RESET};
      unique case (op)
         OP_PROG: begin
            if (byp) begin // RQ7
               r = (step == 3'd0) ? {2'b00, 20'h00000, `CMD_PROGRAM} : {2'b11, 20'h00000, d};
            end else begin
               unique case (step)
                  3'd0: r = {2'b00, `UNLOCK1_ADDR, `UNLOCK1_DATA};
                  3'd1: r = {2'b00, `UNLOCK2_ADDR, `UNLOCK2_DATA};
                  3'd2: r = {2'b00, `UNLOCK1_ADDR, `CMD_PROGRAM};
                  default: r = {2'b11, 20'h00000, d}; // RQ6
               endcase
            end
         end
         OP_SECT_ERASE, OP_CHIP_ERASE: begin
            unique case (step)
               3'd0, 3'd3: r = {2'b00, `UNLOCK1_ADDR, `UNLOCK1_DATA};
               3'd1, 3'd4: r = {2'b00, `UNLOCK2_ADDR, `UNLOCK2_DATA};
               3'd2: r = {2'b00, `UNLOCK1_ADDR, `CMD_ERASE_SETUP};
               default: begin // RQ8
                  if (op == OP_SECT_ERASE) begin
                     r = {2'b11, 20'h00000, `CMD_SECTOR_ERASE}; // RQ11
                  end else begin
                     r = {2'b10, `UNLOCK1_ADDR, `CMD_CHIP_ERASE};
                  end
               end
            endcase
         end
         OP_SUSPEND: r = {2'b10, 20'h00000, `CMD_SUSPEND}; // RQ14
         OP_RESUME: r = {2'b10, 20'h00000, `CMD_RESUME}; // RQ14
         OP_BYPASS_ENTER: begin
            unique case (step)
               3'd0: r = {2'b00, `UNLOCK1_ADDR, `UNLOCK1_DATA};
               3'd1: r = {2'b00, `UNLOCK2_ADDR, `UNLOCK2_DATA};
               default: r = {2'b10, `UNLOCK1_ADDR, `CMD_BYPASS};
            endcase
         end
         OP_BYPASS_EXIT: begin
            if (step == 3'd0) begin
               r = {2'b00, 20'h00000, `CMD_BYPASS_EXIT1};
            end else begin
               r = {2'b10, 20'h00000, `CMD_BYPASS_EXIT2};
            end
         end
         default: r = {1'b1, 1'b0, 20'h00000, `CMD_RESET}; // RQ18
      endcase
      return r;
   endfunction

   assign seq = seq_step(op_ff, step_ff, bypass_active, udata_ff);

   ////////////////////////////////////////////////////////////////////////////////
   // Ready/busy pin is open drain from another domain
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdy_meta_ff <= 1'b0;
         rdy_sync_ff <= 1'b0;
         flash_busy <= 1'b1;
      end else begin
         rdy_meta_ff <= ready_busy_output;
         rdy_sync_ff <= rdy_meta_ff;
         flash_busy <= ~rdy_sync_ff; // RQ9
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= ST_IDLE;
         op_ff <= OP_READ;
         uaddr_ff <= 21'h000000;
         udata_ff <= 16'h0000;
         step_ff <= 3'd0;
         cnt_ff <= 16'h0000;
         poll_first_ff <= 1'b0;
         prev_ff <= 16'h0000;
         start_ff <= 1'b0;
         wr_ff <= 1'b0;
         a_ff <= 20'h00000;
         am1_ff <= 1'b0;
         wd_ff <= 16'h0000;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 16'h0000;
         rsp_err <= 1'b0;
         bypass_active <= 1'b0;
         byte_mode <= 1'b0;
         byte_n <= 1'b1;
         reset_n <= 1'b0;
      end else begin
         start_ff <= 1'b0;
         rsp_valid <= 1'b0;
         unique case (st_ff)
            ST_IDLE: begin
               // Chip select stays high here: the flash drops to standby
               reset_n <= 1'b1; // RQ17
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  op_ff <= cmd_op;
                  uaddr_ff <= cmd_addr;
                  udata_ff <= cmd_data;
                  step_ff <= 3'd0;
                  cnt_ff <= 16'h0000;
                  poll_first_ff <= 1'b1;
                  rsp_err <= 1'b0;
                  unique case (cmd_op)
                     OP_HW_RESET: st_ff <= ST_RST_LOW;
                     OP_SET_WIDTH: begin
                        byte_mode <= cmd_data[0]; // RQ2
                        byte_n <= ~cmd_data[0];
                        st_ff <= ST_DONE;
                     end
                     OP_SECT_ERASE, OP_CHIP_ERASE, OP_BYPASS_ENTER: begin
                        // Bypass mode only knows program and exit; refuse erases and a second bypass entry
                        st_ff <= bypass_active ? ST_DONE : ST_ISSUE; // RQ18
                        rsp_err <= bypass_active;
                     end
                     default: st_ff <= ST_ISSUE;
                  endcase
               end
            end
            ST_ISSUE: begin
               start_ff <= 1'b1;
               st_ff <= ST_BUS;
               if (op_ff == OP_READ || op_ff == OP_POLL) begin
                  wr_ff <= 1'b0;
                  a_ff <= byte_mode ? uaddr_ff[20:1] : uaddr_ff[19:0]; // RQ2
                  am1_ff <= uaddr_ff[0];
               end else begin
                  wr_ff <= 1'b1; // RQ4
                  // Word form of an unlock address gives its byte form as {a, ~a[0]}
                  if (seq[36]) begin
                     a_ff <= byte_mode ? uaddr_ff[20:1] : uaddr_ff[19:0]; // RQ5
                     am1_ff <= uaddr_ff[0];
                  end else begin
                     a_ff <= seq[35:16];
                     am1_ff <= ~seq[16];
                  end
                  wd_ff <= seq[15:0];
               end
            end
            ST_BUS: begin
               if (bus_done) begin
                  if (op_ff == OP_READ) begin
                     rsp_data <= bus_rdata; // RQ10
                     st_ff <= ST_DONE;
                  end else if (op_ff == OP_POLL) begin
                     st_ff <= ST_POLL;
                  end else if (seq[37]) begin
                     if (op_ff == OP_BYPASS_ENTER) begin
                        bypass_active <= 1'b1; // RQ7
                     end else if (op_ff == OP_BYPASS_EXIT) begin
                        bypass_active <= 1'b0;
                     end
                     st_ff <= ST_DONE;
                  end else begin
                     step_ff <= step_ff + 3'd1;
                     st_ff <= ST_ISSUE;
                  end
               end
            end
            ST_POLL: begin
               // Done once the toggle bit stops and the pin shows ready
               poll_first_ff <= 1'b0;
               prev_ff <= bus_rdata;
               rsp_data <= bus_rdata;
               if (!poll_first_ff && (bus_rdata[`TOGGLE_BIT] == prev_ff[`TOGGLE_BIT])
                   && rdy_sync_ff) begin
                  st_ff <= ST_DONE; // RQ9
               end else if (!poll_first_ff && prev_ff[`TIMEOUT_BIT]
                            && bus_rdata[`TOGGLE_BIT] != prev_ff[`TOGGLE_BIT]) begin
                  // Still toggling after the time-limit flag: failed or protected
                  rsp_err <= 1'b1; // RQ13
                  st_ff <= ST_DONE;
               end else begin
                  st_ff <= ST_ISSUE;
               end
            end
            ST_RST_LOW: begin
               reset_n <= 1'b0; // RQ15
               bypass_active <= 1'b0;
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff == 16'(RST_CYC - 1)) begin
                  cnt_ff <= 16'h0000;
                  st_ff <= ST_RST_REC;
               end
            end
            ST_RST_REC: begin
               reset_n <= 1'b1;
               cnt_ff <= cnt_ff + 16'h0001;
               if (cnt_ff == 16'(REC_CYC - 1)) begin
                  st_ff <= ST_DONE;
               end
            end
            ST_DONE: begin
               rsp_valid <= 1'b1;
               st_ff <= ST_IDLE;
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   flash_bus_cycle u_bus (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .start(start_ff),
      .wr(wr_ff),
      .byte_mode(byte_mode),
      .a_in(a_ff),
      .am1_in(am1_ff),
      .wdata(wd_ff),
      .rdata(bus_rdata),
      .done(bus_done),
      .ce_n(ce_n),
      .we_n(we_n),
      .oe_n(oe_n),
      .a(addr),
      .dq_o(dq_o),
      .dq_oe(dq_oe),
      .dq_i(dq_i)
   );

endmodule

`default_nettype wire

//--- hdl/flash_host_pkg.sv
package flash_host_pkg;

   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_PROG = 4'h1,
      OP_SECT_ERASE = 4'h2,
      OP_CHIP_ERASE = 4'h3,
      OP_SUSPEND = 4'h4,
      OP_RESUME = 4'h5,
      OP_POLL = 4'h6,
      OP_ABORT = 4'h7,
      OP_BYPASS_ENTER = 4'h8,
      OP_BYPASS_EXIT = 4'h9,
      OP_HW_RESET = 4'ha,
      OP_SET_WIDTH = 4'hb
   } op_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_SETUP = 2'b01,
      PH_STROBE = 2'b10,
      PH_GAP = 2'b11
   } bus_ph_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ISSUE = 3'b001,
      ST_BUS = 3'b010,
      ST_POLL = 3'b011,
      ST_RST_LOW = 3'b100,
      ST_RST_REC = 3'b101,
      ST_DONE = 3'b110
   } st_t;

endpackage

//--- hdl/flash_host_regs.svh
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// Clock
`define CLK_PERIOD_NS 4

// Read access time, least; rounded up to whole cycles
`define ACCESS_NS 55
`define ACC_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Write strobe low time, least
`define WE_PULSE_NS 35
`define WP_CYC ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Strobe high / bus turnaround time between cycles, least
`define GAP_NS 20
`define GAP_CYC ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Hardware reset pulse and recovery, least
`define RST_PULSE_NS 500
`define RST_CYC ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_REC_NS 200
`define REC_CYC ((`RST_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Unlock addresses (word form) and command codes
`define UNLOCK1_ADDR 20'h00555
`define UNLOCK2_ADDR 20'h002aa
`define UNLOCK1_DATA 16'h00aa
`define UNLOCK2_DATA 16'h0055
`define CMD_PROGRAM 16'h00a0
`define CMD_ERASE_SETUP 16'h0080
`define CMD_SECTOR_ERASE 16'h0030
`define CMD_CHIP_ERASE 16'h0010
`define CMD_SUSPEND 16'h00b0
`define CMD_RESUME 16'h0030
`define CMD_RESET 16'h00f0
`define CMD_BYPASS 16'h0020
`define CMD_BYPASS_EXIT1 16'h0090
`define CMD_BYPASS_EXIT2 16'h0000

// Status bit positions
`define TOGGLE_BIT 6
`define TIMEOUT_BIT 5

`endif

//--- verif/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.svh"
module flash_dev_model #(
   parameter int PROG_T = 40,
   parameter int ERASE_T = 300,
   parameter int SLEEP_T = 20,
   parameter logic [3:0] PROT = 4'hf
) (
   input wire logic reset_n,
   input wire logic vcc_ok,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [19:0] addr,
   input wire logic [15:0] dq_o,
   output logic [15:0] dq_i,
   output logic ready_busy_output
);
   logic [15:0] mem [256];
   logic [15:0] d, rd, rd_last = 16'h0000;
   logic [7:0] a;
   logic held = 1'b0, byp = 1'b0, tog = 1'b0;
   int s = 0, bsy = 0;
   int quiet = 0;
   logic asleep;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
   // Busy hides array data behind a toggling status word
   assign rd = (bsy != 0 && !held) ? {9'h000, tog, 6'h00} : mem[addr[7:0]];
   // Released bus shows the inverse so stale data cannot pass
   assign dq_i = (!ce_n && !oe_n) ? rd : ~rd_last;
   assign ready_busy_output = !(bsy != 0 && !held);
   // Sleeps while the address sits still; data stays valid, so reads need no wake-up
   always @(addr) quiet = 0;
   always #10 if (quiet < SLEEP_T) quiet = quiet + 1;
   assign asleep = (quiet == SLEEP_T);
   always #10 if (bsy != 0 && !held) bsy = bsy - 1;
   always @(posedge oe_n) begin
      rd_last = rd;
      if (bsy != 0 && !held) tog = ~tog;
   end
   always @(posedge we_n or negedge reset_n) begin
      if (!reset_n) begin
         s = 0;
         held = 1'b0;
         byp = 1'b0;
         bsy = 0;
      end else if (!ce_n && vcc_ok) begin
         a = addr[7:0];
         d = dq_o;
         if (bsy != 0 && !held) begin
            if (d == `CMD_SUSPEND) held = 1'b1;
         end else if (held && s == 0 && d == `CMD_RESUME) held = 1'b0;
         else case (s)
            0: s = (byp && d == `CMD_PROGRAM) ? 6 : (byp && d == `CMD_BYPASS_EXIT1) ? 7 :
                  (addr == `UNLOCK1_ADDR && d == `UNLOCK1_DATA) ? 1 : 0;
            1, 4: s = (addr == `UNLOCK2_ADDR && d == `UNLOCK2_DATA) ? s + 1 : 0;
            2: begin
               s = 0;
               if (addr == `UNLOCK1_ADDR && d == `CMD_PROGRAM) s = 6;
               if (addr == `UNLOCK1_ADDR && d == `CMD_ERASE_SETUP) s = 3;
               if (addr == `UNLOCK1_ADDR && d == `CMD_BYPASS) byp = 1'b1;
            end
            3: s = (addr == `UNLOCK1_ADDR && d == `UNLOCK1_DATA) ? 4 : 0;
            5: begin
               s = 0;
               for (int i = 0; i < 256; i++)
                  if ((d == `CMD_CHIP_ERASE || (d == `CMD_SECTOR_ERASE && i[7:4] == a[7:4]))
                     && i[7:4] != PROT) mem[i] = 16'hffff;
               if (d == `CMD_CHIP_ERASE || d == `CMD_SECTOR_ERASE) bsy = ERASE_T;
            end
            6: begin
               s = 0;
               if (a[7:4] != PROT) mem[a] = mem[a] & d;
               bsy = PROG_T;
            end
            default: begin
               s = 0;
               if (d == `CMD_BYPASS_EXIT2) byp = 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- verif/flash_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // User side
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic flash_busy,
   input wire logic byte_mode,
   // Flash pins
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [19:0] addr,
   input wire logic [15:0] dq_oe,
   input wire logic reset_n,
   input wire logic ready_busy_output
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   a_no_overlap: assert property (!(!oe_n && !we_n))
      else $error("output and write strobes both low");
   a_addr_stable: assert property (!ce_n && $past(!ce_n) |-> $stable(addr))
      else $error("address moved inside a cycle");
   a_we_pulse: assert property ($fell(we_n) |-> (!we_n) [*8])
      else $error("write strobe too short");
   a_wr_drive: assert property (!we_n |-> dq_oe[7:0] == 8'hff)
      else $error("data not driven during write");
   // Byte mode keeps driving the lowest address bit on the top data line
   a_rd_release: assert property (!oe_n |-> dq_oe == {byte_mode, 15'h0000})
      else $error("data driven during read");
   a_standby_idle: assert property (cmd_ready |-> ce_n)
      else $error("chip select low while idle");
   a_rsp_ready: assert property (rsp_valid |=> cmd_ready)
      else $error("not ready after answer");
   a_reset_pulse: assert property ($fell(reset_n) |-> (!reset_n) [*2])
      else $error("reset pulse too short");
   a_busy_follow: assert property (ready_busy_output [*4] |-> !flash_busy)
      else $error("busy flag ignores ready pin");
   ////////////////////////////////////////////////////////////////////////
   c_write: cover property ($fell(we_n));
   c_read: cover property ($fell(oe_n));
   c_reset: cover property ($fell(reset_n));
endmodule
`default_nettype wire

//--- verif/flash_host_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_tb;
   import flash_host_pkg::*;
   logic ref_clk, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_err, flash_busy, bypass_active;
   logic byte_mode, ce_n, we_n, oe_n, byte_n, reset_n, ready_busy_output, vcc_ok, er;
   op_t cmd_op;
   logic [20:0] cmd_addr;
   logic [19:0] addr;
   logic [15:0] cmd_data, rsp_data, dq_o, dq_oe, dq_i, rd;
   int err_count = 0;
   int check_count = 0;
   int wr_n = 0;
   flash_host_ctrl #(.RST_CYC(2), .REC_CYC(2)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
      .flash_busy(flash_busy), .bypass_active(bypass_active), .byte_mode(byte_mode),
      .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe),
      .dq_i(dq_i), .byte_n(byte_n), .reset_n(reset_n), .ready_busy_output(ready_busy_output));
   flash_dev_model dev (.reset_n(reset_n), .vcc_ok(vcc_ok), .ce_n(ce_n), .we_n(we_n),
      .oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_i(dq_i), .ready_busy_output(ready_busy_output));
   always @(negedge we_n) wr_n++;
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Callers sit at a falling edge; answer is taken in its one valid cycle
   task automatic send(input op_t op, input logic [20:0] a, input logic [15:0] d);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 6000) begin
         @(negedge ref_clk);
         n++;
      end
      rd = rsp_data;
      er = rsp_err;
      if (n >= 6000) begin
         err_count++;
         $display("mismatch %0t no answer", $time);
         end_of_test();
      end
   endtask
   task automatic rd_chk(input logic [20:0] a, input logic [15:0] exp);
      send(OP_READ, a, 16'h0000);
      cmp(rd, exp);
   endtask
   task automatic poll_ok(input logic [20:0] a);
      send(OP_POLL, a, 16'h0000);
      cmp({15'h0000, er}, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_width();
      send(OP_SET_WIDTH, 21'h000000, 16'h0001);
      cmp({14'h0000, byte_mode, byte_n}, 16'h0002);
      send(OP_SET_WIDTH, 21'h000000, 16'h0000);
      cmp({14'h0000, byte_mode, byte_n}, 16'h0001);
   endtask
   task automatic t_chip();
      send(OP_CHIP_ERASE, 21'h000000, 16'h0000);
      poll_ok(21'h000000);
      rd_chk(21'h000005, 16'hffff);
      rd_chk(21'h0000f3, 16'h0000);
   endtask
   task automatic t_prog();
      int w;
      w = wr_n;
      send(OP_PROG, 21'h000005, 16'h1234);
      cmp(16'(wr_n - w), 16'h0004);
      repeat (4) @(negedge ref_clk);
      cmp({15'h0000, flash_busy}, 16'h0001);
      poll_ok(21'h000005);
      rd_chk(21'h000005, 16'h1234);
      send(OP_PROG, 21'h000015, 16'h5a5a);
      poll_ok(21'h000015);
   endtask
   task automatic t_bypass();
      int w;
      send(OP_BYPASS_ENTER, 21'h000000, 16'h0000);
      cmp({15'h0000, bypass_active}, 16'h0001);
      w = wr_n;
      send(OP_PROG, 21'h000006, 16'h00ab);
      cmp(16'(wr_n - w), 16'h0002);
      poll_ok(21'h000006);
      rd_chk(21'h000006, 16'h00ab);
      send(OP_SECT_ERASE, 21'h000000, 16'h0000);
      cmp({15'h0000, er}, 16'h0001);
      send(OP_BYPASS_EXIT, 21'h000000, 16'h0000);
      cmp({15'h0000, bypass_active}, 16'h0000);
   endtask
   task automatic t_suspend();
      send(OP_SECT_ERASE, 21'h000000, 16'h0000);
      send(OP_SUSPEND, 21'h000000, 16'h0000);
      poll_ok(21'h000000);
      rd_chk(21'h000015, 16'h5a5a);
      send(OP_RESUME, 21'h000000, 16'h0000);
      poll_ok(21'h000000);
      rd_chk(21'h000005, 16'hffff);
      rd_chk(21'h000015, 16'h5a5a);
   endtask
   task automatic t_lock();
      vcc_ok = 1'b0;
      send(OP_PROG, 21'h000020, 16'h0000);
      vcc_ok = 1'b1;
      rd_chk(21'h000020, 16'hffff);
   endtask
   task automatic t_reset();
      send(OP_SECT_ERASE, 21'h000030, 16'h0000);
      send(OP_HW_RESET, 21'h000000, 16'h0000);
      poll_ok(21'h000030);
      send(OP_ABORT, 21'h000000, 16'h0000);
      rd_chk(21'h000015, 16'h5a5a);
      // Address left still long enough for the flash to fall asleep
      repeat (60) @(negedge ref_clk);
      cmp({15'h0000, dev.asleep}, 16'h0001);
      send(OP_SET_WIDTH, 21'h000000, 16'h0001);
      rd_chk(21'h00002b, 16'h005a);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_READ;
      cmd_addr = 21'h000000;
      cmd_data = 16'h0000;
      vcc_ok = 1'b1;
      repeat (3) @(negedge ref_clk);
      arst_n = 1'b1;
      @(negedge ref_clk);
      t_width();
      t_chip();
      t_prog();
      t_bypass();
      t_suspend();
      t_lock();
      t_reset();
      end_of_test();
   end
endmodule
bind flash_host_ctrl flash_host_checker chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .flash_busy(flash_busy),
   .byte_mode(byte_mode), .ce_n(ce_n),
   .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_oe(dq_oe), .reset_n(reset_n),
   .ready_busy_output(ready_busy_output));
`default_nettype wire
